// ==== rtl/rcbt_pkg.sv ====
/*
 * Package for the reload/capture/baud timer: register offsets, control
 * field positions, reset values, event bit positions and the mode codes.
 * Assumes an 8-bit register port with byte-wide data.
 */
package rcbt_pkg;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc0;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'hc1;
	localparam logic [7:0] ADDR_CONTROL    = 8'hc8;
	localparam logic [7:0] ADDR_RELOAD_LO  = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HI  = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LO   = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HI   = 8'hcd;

	// Control register field positions
	localparam int CTL_OVERFLOW_FLAG  = 7;
	localparam int CTL_EXT_EDGE_FLAG  = 6;
	localparam int CTL_RX_CLK_SEL     = 5;
	localparam int CTL_TX_CLK_SEL     = 4;
	localparam int CTL_TRIG_ENABLE    = 3;
	localparam int CTL_RUN            = 2;
	localparam int CTL_COUNTER_SELECT = 1;
	localparam int CTL_CAPTURE_SELECT = 0;

	// Interrupt status and mask bit positions
	localparam int EVT_OVERFLOW = 0;
	localparam int EVT_EXT_EDGE = 1;

	// Values after reset, and the terminal count
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [15:0] RELOAD_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [1:0]  IRQ_RESET      = 2'h0;
	localparam logic [15:0] COUNT_TERMINAL = 16'hffff;

	// Operating modes
	typedef enum logic [1:0] {
		RCBT_MODE_STOP    = 2'b00,
		RCBT_MODE_RELOAD  = 2'b01,
		RCBT_MODE_CAPTURE = 2'b10,
		RCBT_MODE_BAUD    = 2'b11
	} rcbt_mode_t;

endpackage

// ==== rtl/rcbt_fall_detect.sv ====
/*
 * Falling-edge detector for the shared count/trigger pin.
 * Assumes the pin is already synchronous to ref_clk and idles high.
 */
`timescale 1ns/1ps
module rcbt_fall_detect (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output wire logic fall
);

	logic pin_q;

	// Previous level, held high at reset so no false edge appears
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= pin;
		end
	end

	assign fall = pin_q & ~pin;

endmodule // rcbt_fall_detect

// ==== rtl/rcbt_count16.sv ====
/*
 * 16-bit up counter with byte writes, parallel load and overflow pulse.
 * Assumes the caller decides when a tick or a load is due.
 */
`timescale 1ns/1ps
module rcbt_count16 (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        load_en,
	input  wire logic [15:0] load_val,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	output logic      [15:0] count_q,
	output wire logic        ovf
);

	logic [15:0] count_d;

	// Overflow when a tick meets the terminal count
	assign ovf = tick & (count_q == rcbt_pkg::COUNT_TERMINAL);

	// Software write beats load, load beats counting
	always_comb begin
		count_d = count_q;
		if (wr_lo || wr_hi) begin
			if (wr_lo) begin
				count_d[7:0] = wdata;
			end
			if (wr_hi) begin
				count_d[15:8] = wdata;
			end
		end else if (load_en) begin
			count_d = load_val;
		end else if (tick) begin
			count_d = count_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= rcbt_pkg::COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

endmodule // rcbt_count16

// ==== rtl/rcbt_timer.sv ====
/*
 * Reload/capture/baud timer: control register, reload pair, count pair,
 * mode decode, flags, interrupt and serial clock pulse selection.
 * Assumes a single-cycle register port and inputs synchronous to ref_clk.
 */
// Summary of operation
// - The 8-bit read/write control register at 0xc8 resets to zero.
// - Receive pulses follow this timer when their select is set, else the other timer.
// - Transmit pulses follow this timer when their select is set, else the other timer.
// - An enabled trigger fall captures in capture mode or reloads in auto-reload mode; a disabled one is ignored.
// - Selects, capture select and run give the mode; run low stops the timer.
// - In auto-reload mode an overflow sets the overflow flag and loads the reload pair.
// - In capture mode every overflow sets the overflow flag.
// - In capture mode an enabled trigger fall copies the count into the reload pair.
// - Either clock select with run gives baud mode; its overflows feed the serial clocks.
// - One pin drives both the event counting path and the falling-edge trigger path.
// - No serial port is present, so the selects only steer the mode and the pulse outputs.
// - Seven registers exist: count high and low, reload high and low, control, interrupt status and interrupt mask.
// - The reload low byte sits at 0xca and the high byte at 0xcb, read/write, reset to zero.
`timescale 1ns/1ps
module rcbt_timer (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       ext_trigger_pin,
	input  wire logic       other_timer_ovf,
	output wire logic       rx_clk_pulse,
	output wire logic       tx_clk_pulse,
	output wire logic       irq
);

	// Mode decode from the control byte
	function automatic rcbt_pkg::rcbt_mode_t decode_mode(input logic [7:0] ctl);
		rcbt_pkg::rcbt_mode_t m;
		if (!ctl[rcbt_pkg::CTL_RUN]) begin
			m = rcbt_pkg::RCBT_MODE_STOP;
		end else if (ctl[rcbt_pkg::CTL_RX_CLK_SEL] || ctl[rcbt_pkg::CTL_TX_CLK_SEL]) begin
			m = rcbt_pkg::RCBT_MODE_BAUD;
		end else if (ctl[rcbt_pkg::CTL_CAPTURE_SELECT]) begin
			m = rcbt_pkg::RCBT_MODE_CAPTURE;
		end else begin
			m = rcbt_pkg::RCBT_MODE_RELOAD;
		end
		return m;
	endfunction

	// Register address match, used by both write and read decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	logic                 rst_meta_q;
	logic                 rst_sync_n;
	logic [7:0]           control_q;
	logic [7:0]           control_d;
	logic [15:0]          reload_q;
	logic [15:0]          reload_d;
	logic [1:0]           irq_status_q;
	logic [1:0]           irq_status_d;
	logic [1:0]           irq_mask_q;
	logic                 own_ovf_q;
	logic [15:0]          count_q;
	logic [7:0]           rd_mux;
	rcbt_pkg::rcbt_mode_t mode;
	wire logic            trig_fall;
	wire logic            cnt_ovf;
	wire logic            tick;
	wire logic            load_en;
	wire logic            trig_enable;
	wire logic            capture_now;
	wire logic            edge_event;
	wire logic            ovf_event;
	wire logic            wr_ctl;
	wire logic            wr_rld_lo;
	wire logic            wr_rld_hi;
	wire logic            wr_cnt_lo;
	wire logic            wr_cnt_hi;
	wire logic            wr_stat;
	wire logic            wr_mask;
	wire logic [1:0]      evt_set;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Write strobes per register
	assign wr_ctl    = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_CONTROL);
	assign wr_rld_lo = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_RELOAD_LO);
	assign wr_rld_hi = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_RELOAD_HI);
	assign wr_cnt_lo = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_COUNT_LO);
	assign wr_cnt_hi = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_COUNT_HI);
	assign wr_stat   = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_IRQ_STATUS);
	assign wr_mask   = reg_wr & hit(reg_addr, rcbt_pkg::ADDR_IRQ_MASK);

	// Mode and trigger qualification
	assign mode        = decode_mode(control_q);
	assign trig_enable = control_q[rcbt_pkg::CTL_TRIG_ENABLE];
	assign edge_event  = trig_fall & trig_enable;

	// One pin feeds both the count path and the trigger path
	rcbt_fall_detect u_pin_fall (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.pin     (ext_trigger_pin),
		.fall    (trig_fall)
	);

	// Counter mode counts pin edges, timer mode counts every clock
	assign tick = (mode != rcbt_pkg::RCBT_MODE_STOP) &
		(control_q[rcbt_pkg::CTL_COUNTER_SELECT] ? trig_fall : 1'b1);

	// Reload on overflow in reload and baud modes, or on a trigger in reload mode
	assign load_en = (cnt_ovf & ((mode == rcbt_pkg::RCBT_MODE_RELOAD) |
		(mode == rcbt_pkg::RCBT_MODE_BAUD))) |
		(edge_event & (mode == rcbt_pkg::RCBT_MODE_RELOAD));

	// Capture only in capture mode with the trigger enabled
	assign capture_now = edge_event & (mode == rcbt_pkg::RCBT_MODE_CAPTURE);

	// Overflow flag events exclude baud mode
	assign ovf_event = cnt_ovf & ((mode == rcbt_pkg::RCBT_MODE_RELOAD) |
		(mode == rcbt_pkg::RCBT_MODE_CAPTURE));

	rcbt_count16 u_count (
		.ref_clk  (ref_clk),
		.rst_n    (rst_sync_n),
		.tick     (tick),
		.load_en  (load_en),
		.load_val (reload_q),
		.wr_lo    (wr_cnt_lo),
		.wr_hi    (wr_cnt_hi),
		.wdata    (reg_wdata),
		.count_q  (count_q),
		.ovf      (cnt_ovf)
	);

	// Control next value; hardware set beats a software clear of a flag
	always_comb begin
		control_d = control_q;
		if (wr_ctl) begin
			control_d = reg_wdata;
		end
		if (ovf_event) begin
			control_d[rcbt_pkg::CTL_OVERFLOW_FLAG] = 1'b1;
		end
		if (edge_event) begin
			control_d[rcbt_pkg::CTL_EXT_EDGE_FLAG] = 1'b1;
		end
	end

	// Reload pair; a capture wins over a software write in the same cycle
	always_comb begin
		reload_d = reload_q;
		if (wr_rld_lo) begin
			reload_d[7:0] = reg_wdata;
		end
		if (wr_rld_hi) begin
			reload_d[15:8] = reg_wdata;
		end
		if (capture_now) begin
			reload_d = count_q;
		end
	end

	// Sticky status, write one to clear, new events win
	assign evt_set = {edge_event, ovf_event};
	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_stat) begin
			irq_status_d = irq_status_q & ~reg_wdata[1:0];
		end
		irq_status_d = irq_status_d | evt_set;
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			control_q    <= rcbt_pkg::CONTROL_RESET;
			reload_q     <= rcbt_pkg::RELOAD_RESET;
			irq_status_q <= rcbt_pkg::IRQ_RESET;
			irq_mask_q   <= rcbt_pkg::IRQ_RESET;
		end else begin
			control_q    <= control_d;
			reload_q     <= reload_d;
			irq_status_q <= irq_status_d;
			irq_mask_q   <= wr_mask ? reg_wdata[1:0] : irq_mask_q;
		end
	end

	// Overflow pulse for the serial clocks exists only in baud mode
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			own_ovf_q <= 1'b0;
		end else begin
			own_ovf_q <= cnt_ovf & (mode == rcbt_pkg::RCBT_MODE_BAUD);
		end
	end

	// Nothing inside consumes these; they are offered to whatever serial logic exists
	assign rx_clk_pulse = control_q[rcbt_pkg::CTL_RX_CLK_SEL] ? own_ovf_q :
		other_timer_ovf;
	assign tx_clk_pulse = control_q[rcbt_pkg::CTL_TX_CLK_SEL] ? own_ovf_q :
		other_timer_ovf;

	assign irq = |(irq_status_q & irq_mask_q);

	// Read selection; unmapped offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (1'b1)
			hit(reg_addr, rcbt_pkg::ADDR_CONTROL):    rd_mux = control_q;
			hit(reg_addr, rcbt_pkg::ADDR_RELOAD_LO):  rd_mux = reload_q[7:0];
			hit(reg_addr, rcbt_pkg::ADDR_RELOAD_HI):  rd_mux = reload_q[15:8];
			hit(reg_addr, rcbt_pkg::ADDR_COUNT_LO):   rd_mux = count_q[7:0];
			hit(reg_addr, rcbt_pkg::ADDR_COUNT_HI):   rd_mux = count_q[15:8];
			hit(reg_addr, rcbt_pkg::ADDR_IRQ_STATUS): rd_mux = {6'h00, irq_status_q};
			hit(reg_addr, rcbt_pkg::ADDR_IRQ_MASK):   rd_mux = {6'h00, irq_mask_q};
			default:                                  rd_mux = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Control write lands, flags aside
	ctl_write_lands_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		wr_ctl |=> control_q[5:0] == $past(reg_wdata[5:0]))
		else $error("control write not stored");

	// Receive pulse source follows its select
	rx_source_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(!control_q[rcbt_pkg::CTL_RX_CLK_SEL] && rx_clk_pulse) |-> other_timer_ovf)
		else $error("receive pulse from wrong timer");

	// Transmit pulse from own overflow one cycle after it
	tx_own_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(cnt_ovf && mode == rcbt_pkg::RCBT_MODE_BAUD && !wr_ctl &&
		control_q[rcbt_pkg::CTL_TX_CLK_SEL]) |=> tx_clk_pulse)
		else $error("transmit pulse missing after overflow");

	// Disabled trigger leaves the edge flag clear
	trig_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(trig_fall && !trig_enable && !wr_ctl &&
		!control_q[rcbt_pkg::CTL_EXT_EDGE_FLAG]) |=> !control_q[rcbt_pkg::CTL_EXT_EDGE_FLAG])
		else $error("edge flag set while trigger disabled");

	// Stopped timer holds its count
	stop_holds_count_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(!control_q[rcbt_pkg::CTL_RUN] && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(count_q))
		else $error("count moved while stopped");

	// Overflow in reload mode reloads and flags
	reload_on_ovf_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(cnt_ovf && mode == rcbt_pkg::RCBT_MODE_RELOAD && !wr_cnt_lo && !wr_cnt_hi) |=>
		(count_q == $past(reload_q)) && control_q[rcbt_pkg::CTL_OVERFLOW_FLAG])
		else $error("reload or flag missing on overflow");

	// Capture copies the count into the reload pair
	capture_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(trig_fall && trig_enable && mode == rcbt_pkg::RCBT_MODE_CAPTURE) |=>
		reload_q == $past(count_q))
		else $error("capture did not copy count");

	// Baud overflow reloads without the flag
	baud_no_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(cnt_ovf && mode == rcbt_pkg::RCBT_MODE_BAUD && !wr_ctl && !wr_cnt_lo && !wr_cnt_hi &&
		!control_q[rcbt_pkg::CTL_OVERFLOW_FLAG]) |=>
		!control_q[rcbt_pkg::CTL_OVERFLOW_FLAG] && count_q == $past(reload_q))
		else $error("baud overflow flagged or not reloaded");

	// Enabled trigger edge sets the edge flag and status
	edge_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(trig_fall && trig_enable) |=>
		control_q[rcbt_pkg::CTL_EXT_EDGE_FLAG] && irq_status_q[rcbt_pkg::EVT_EXT_EDGE])
		else $error("edge flag not set");

	// Overflow status under its mask raises the interrupt
	irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(irq_status_q[rcbt_pkg::EVT_OVERFLOW] && irq_mask_q[rcbt_pkg::EVT_OVERFLOW]) |-> irq)
		else $error("interrupt missing");

	// Capture-mode overflow raises the flag and its status bit
	capture_ovf_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
		(cnt_ovf && mode == rcbt_pkg::RCBT_MODE_CAPTURE) |=>
		control_q[rcbt_pkg::CTL_OVERFLOW_FLAG] && irq_status_q[rcbt_pkg::EVT_OVERFLOW])
		else $error("capture overflow not flagged");

endmodule // rcbt_timer

// ==== verif/rcbt_trig_model.sv ====
/*
 * Far-side model: the shared count/trigger pin and the other timer's
 * overflow pulse. Assumes the caller enters its tasks just after a
 * rising edge of ref_clk.
 */
`timescale 1ns/1ps
module rcbt_trig_model (
	input  wire logic ref_clk,
	output logic      ext_trigger_pin,
	output logic      other_timer_ovf
);
	// Pin idles high, the overflow pulse idles low
	initial begin
		ext_trigger_pin = 1'b1;
		other_timer_ovf = 1'b0;
	end

	// One falling edge on the shared pin, then settle time for the detector
	task automatic fall_pulse();
		@(posedge ref_clk);
		ext_trigger_pin <= 1'b0;
		@(posedge ref_clk);
		ext_trigger_pin <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	// Level of the other timer's overflow line
	task automatic set_ovf(input logic v);
		other_timer_ovf <= v;
	endtask
endmodule // rcbt_trig_model

// ==== verif/rcbt_timer_tb_top.sv ====
/*
 * Self-checking bench for the reload/capture/baud timer.
 * Assumes the register port and pin model of rcbt_timer as declared.
 */
`timescale 1ns/1ps
module rcbt_timer_tb_top;
	logic       ref_clk;
	logic       rst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       ext_trigger_pin;
	logic       other_timer_ovf;
	logic       rx_clk_pulse;
	logic       tx_clk_pulse;
	logic       irq;
	int         n_fail;
	int         checked;

	rcbt_timer u_rcbt_timer (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.ext_trigger_pin(ext_trigger_pin),
		.other_timer_ovf(other_timer_ovf),
		.rx_clk_pulse   (rx_clk_pulse),
		.tx_clk_pulse   (tx_clk_pulse),
		.irq            (irq)
	);

	rcbt_trig_model u_rcbt_trig_model (
		.ref_clk        (ref_clk),
		.ext_trigger_pin(ext_trigger_pin),
		.other_timer_ovf(other_timer_ovf)
	);

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Write strobe, then a gap cycle so strobes never change twice per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
		chk(v, exp);
		@(posedge ref_clk);
	endtask

	// Reset values, unmapped place and the other timer's pass-through
	task automatic t_reset();
		rc(rcbt_pkg::ADDR_CONTROL, 8'h00);
		rc(rcbt_pkg::ADDR_RELOAD_LO, 8'h00);
		rc(rcbt_pkg::ADDR_RELOAD_HI, 8'h00);
		rc(rcbt_pkg::ADDR_COUNT_HI, 8'h00);
		rc(8'h55, 8'h00);
		wr(rcbt_pkg::ADDR_RELOAD_HI, 8'ha5);
		rc(rcbt_pkg::ADDR_RELOAD_HI, 8'ha5);
		u_rcbt_trig_model.set_ovf(1'b1);
		@(negedge ref_clk);
		chk({7'h0, rx_clk_pulse}, 8'h01);
		chk({7'h0, tx_clk_pulse}, 8'h01);
		@(posedge ref_clk);
		u_rcbt_trig_model.set_ovf(1'b0);
	endtask

	// Auto-reload overflow, flags, masking, stop
	task automatic t_reload();
		wr(rcbt_pkg::ADDR_RELOAD_LO, 8'hfe);
		wr(rcbt_pkg::ADDR_RELOAD_HI, 8'hff);
		wr(rcbt_pkg::ADDR_COUNT_LO, 8'hfe);
		wr(rcbt_pkg::ADDR_COUNT_HI, 8'hff);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h04);
		@(posedge ref_clk); // Overflow lands one edge after the count reaches ffff
		rc(rcbt_pkg::ADDR_CONTROL, 8'h84);
		rc(rcbt_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(rcbt_pkg::ADDR_IRQ_MASK, 8'h01);
		chk({7'h0, irq}, 8'h01);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h80);
		rc(rcbt_pkg::ADDR_CONTROL, 8'h80);
		rc(rcbt_pkg::ADDR_COUNT_HI, 8'hff);
		rc(rcbt_pkg::ADDR_COUNT_LO, 8'hff);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h00);
		wr(rcbt_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk({7'h0, irq}, 8'h00);
		rc(rcbt_pkg::ADDR_CONTROL, 8'h00);
	endtask

	// Capture on a pin edge, ignored edges, capture-mode overflow
	task automatic t_capture();
		wr(rcbt_pkg::ADDR_COUNT_LO, 8'h34);
		wr(rcbt_pkg::ADDR_COUNT_HI, 8'h12);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h0f);
		u_rcbt_trig_model.fall_pulse();
		rc(rcbt_pkg::ADDR_RELOAD_LO, 8'h34);
		rc(rcbt_pkg::ADDR_RELOAD_HI, 8'h12);
		rc(rcbt_pkg::ADDR_COUNT_LO, 8'h35);
		rc(rcbt_pkg::ADDR_CONTROL, 8'h4f);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h0e);
		u_rcbt_trig_model.fall_pulse();
		rc(rcbt_pkg::ADDR_COUNT_LO, 8'h34);
		rc(rcbt_pkg::ADDR_CONTROL, 8'h4e);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h07);
		u_rcbt_trig_model.fall_pulse();
		rc(rcbt_pkg::ADDR_COUNT_LO, 8'h35);
		rc(rcbt_pkg::ADDR_RELOAD_LO, 8'h34);
		rc(rcbt_pkg::ADDR_CONTROL, 8'h07);
		wr(rcbt_pkg::ADDR_COUNT_LO, 8'hff);
		wr(rcbt_pkg::ADDR_COUNT_HI, 8'hff);
		u_rcbt_trig_model.fall_pulse();
		rc(rcbt_pkg::ADDR_CONTROL, 8'h87);
		rc(rcbt_pkg::ADDR_COUNT_HI, 8'h00);
		rc(rcbt_pkg::ADDR_RELOAD_LO, 8'h34);
		rc(rcbt_pkg::ADDR_IRQ_STATUS, 8'h03);
		wr(rcbt_pkg::ADDR_CONTROL, 8'h00);
		wr(rcbt_pkg::ADDR_IRQ_STATUS, 8'h03);
	endtask

	// Baud mode per clock select; period of two cycles gives ten pulses
	task automatic t_baud();
		logic [7:0] sel [3];
		int         tx_n;
		int         rx_n;
		sel = '{8'h14, 8'h24, 8'h35};
		for (int k = 0; k < 3; k++) begin
			wr(rcbt_pkg::ADDR_RELOAD_LO, 8'hfe);
			wr(rcbt_pkg::ADDR_RELOAD_HI, 8'hff);
			wr(rcbt_pkg::ADDR_COUNT_LO, 8'hfe);
			wr(rcbt_pkg::ADDR_COUNT_HI, 8'hff);
			wr(rcbt_pkg::ADDR_CONTROL, sel[k]);
			repeat (4) @(posedge ref_clk);
			tx_n = 0;
			rx_n = 0;
			for (int i = 0; i < 20; i++) begin
				@(negedge ref_clk);
				// Unknown levels count as pulses so they cannot hide
				if (tx_clk_pulse !== 1'b0) tx_n++;
				if (rx_clk_pulse !== 1'b0) rx_n++;
			end
			@(posedge ref_clk);
			chk(8'(tx_n), sel[k][4] ? 8'h0a : 8'h00);
			chk(8'(rx_n), sel[k][5] ? 8'h0a : 8'h00);
			rc(rcbt_pkg::ADDR_CONTROL, sel[k]);
			rc(rcbt_pkg::ADDR_COUNT_HI, 8'hff);
			wr(rcbt_pkg::ADDR_CONTROL, 8'h00);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#2000000;
		n_fail++;
		wrap_up();
	end

	// Main sequence
	initial begin
		n_fail = 0;
		checked = 0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_reload();
		t_capture();
		t_baud();
		wrap_up();
	end
endmodule // rcbt_timer_tb_top
